// ### logic/sca_flag_if.sv
`timescale 1ns/1ns
interface sca_flag_if #(
	parameter int unsigned WIDTH = 26
);
	logic ce;
	logic [WIDTH-1:0] set;
	logic rd_clr;
	logic [WIDTH-1:0] flags;

	modport owner (
		input ce,
		input set,
		input rd_clr,
		output flags
	);

	modport user (
		output ce,
		output set,
		output rd_clr,
		input flags
	);
endinterface

// ### logic/sca_pkg.sv
package sca_pkg;

	// ==========================================================
	// Geometry
	localparam int unsigned PORTS = 26;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned IDX_W = 8;

	// ==========================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_TX_LEN_OVF = 8'h11;
	localparam logic [ADDR_W-1:0] OFS_ERR_OVF = 8'h12;
	localparam logic [ADDR_W-1:0] OFS_COL_OVF = 8'h13;
	localparam logic [ADDR_W-1:0] OFS_CLR_CMD = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_RD_CTRL = 8'h15;
	localparam logic [ADDR_W-1:0] OFS_RD_RESULT = 8'h16;

	// ==========================================================
	// Field positions
	localparam int unsigned CLR_SEL_LSB = 0;
	localparam int unsigned CLR_BUSY_BIT = 26;
	localparam int unsigned RD_IDX_LSB = 0;
	localparam int unsigned RD_BUSY_BIT = 8;

	// ==========================================================
	// Values after reset
	localparam logic [PORTS-1:0] FLAGS_RST = 26'h0000000;
	localparam logic [PORTS-1:0] CLR_SEL_RST = 26'h0000000;
	localparam logic [IDX_W-1:0] RD_IDX_RST = 8'h00;
	localparam logic [DATA_W-1:0] RESULT_RST = 32'h00000000;
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;

	// ==========================================================
	// State machines
	typedef enum logic [1:0] {
		CLR_IDLE = 2'b01,
		CLR_RUN = 2'b10
	} sca_clr_state_type;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_FETCH = 2'b10
	} sca_rd_state_type;

endpackage

// ### logic/sca_stat_access.sv
`timescale 1ns/1ns
module sca_stat_access (
	input wire logic clock_in, // Core clock, 25 MHz
	input wire logic arst_n_in, // Async reset, active low
	input wire logic ce_in, // Clock enable, freezes all state when low
	input wire logic [sca_pkg::ADDR_W-1:0] addr_in, // Register address
	input wire logic [sca_pkg::DATA_W-1:0] wdata_in, // Write data
	input wire logic wr_in, // Write strobe
	input wire logic rd_in, // Read strobe
	output logic [sca_pkg::DATA_W-1:0] rdata_out, // Read data, cycle after strobe
	input wire logic [sca_pkg::PORTS-1:0] tx_len_ovf_in, // Tx byte counter wrapped, pulse
	input wire logic [sca_pkg::PORTS-1:0] err_ovf_in, // Error counter wrapped, pulse
	input wire logic [sca_pkg::PORTS-1:0] col_ovf_in, // Collision counter wrapped, pulse
	output logic clr_req_out, // Clear request to counters, level
	output logic [sca_pkg::PORTS-1:0] clr_sel_out, // Ports to clear
	input wire logic clr_done_in, // Counters finished clearing
	output logic cnt_req_out, // Indirect fetch request, level
	output logic [sca_pkg::IDX_W-1:0] cnt_index_out, // Counter index to fetch
	input wire logic [sca_pkg::DATA_W-1:0] cnt_value_in, // Fetched counter value
	input wire logic cnt_valid_in // Fetched value valid
);
	// ==========================================================
	// Declarations
	sca_pkg::sca_clr_state_type clr_state_r;
	sca_pkg::sca_clr_state_type clr_state_nxt;
	sca_pkg::sca_rd_state_type rd_state_r;
	sca_pkg::sca_rd_state_type rd_state_nxt;
	logic [sca_pkg::PORTS-1:0] clr_sel_r;
	logic [sca_pkg::IDX_W-1:0] rd_idx_r;
	logic [sca_pkg::DATA_W-1:0] result_r;
	logic [sca_pkg::DATA_W-1:0] rdata_r;
	logic [sca_pkg::DATA_W-1:0] rdata_nxt;
	logic [sca_pkg::DATA_W-1:0] tx_view;
	logic [sca_pkg::DATA_W-1:0] err_view;
	logic [sca_pkg::DATA_W-1:0] col_view;
	logic [sca_pkg::DATA_W-1:0] clr_cmd_view;
	logic [sca_pkg::DATA_W-1:0] rd_ctrl_view;
	logic clr_busy;
	logic rd_busy;
	logic units_idle;
	logic wr_clr;
	logic wr_rd;
	logic clr_start;
	logic rd_start;
	logic clr_finish;
	logic rd_finish;

	sca_flag_if #(.WIDTH(sca_pkg::PORTS)) tx_if ();
	sca_flag_if #(.WIDTH(sca_pkg::PORTS)) err_if ();
	sca_flag_if #(.WIDTH(sca_pkg::PORTS)) col_if ();

	// ==========================================================
	// Overflow flags
	// Events come from counter logic on this clock, so no synchroniser
	assign tx_if.ce = ce_in;
	assign tx_if.set = tx_len_ovf_in;
	assign tx_if.rd_clr = rd_in && (addr_in == sca_pkg::OFS_TX_LEN_OVF);

	assign err_if.ce = ce_in;
	assign err_if.set = err_ovf_in;
	assign err_if.rd_clr = rd_in && (addr_in == sca_pkg::OFS_ERR_OVF);

	assign col_if.ce = ce_in;
	assign col_if.set = col_ovf_in;
	assign col_if.rd_clr = rd_in && (addr_in == sca_pkg::OFS_COL_OVF);

	sca_sticky #(
		.WIDTH(sca_pkg::PORTS)
	) u_tx_flags (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.fl(tx_if.owner)
	);

	sca_sticky #(
		.WIDTH(sca_pkg::PORTS)
	) u_err_flags (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.fl(err_if.owner)
	);

	sca_sticky #(
		.WIDTH(sca_pkg::PORTS)
	) u_col_flags (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.fl(col_if.owner)
	);

	// ==========================================================
	// Command decode
	assign clr_busy = (clr_state_r == sca_pkg::CLR_RUN);
	assign rd_busy = (rd_state_r == sca_pkg::RD_FETCH);
	// Clear and fetch exclude each other so counters see one job at a time
	assign units_idle = !clr_busy && !rd_busy;
	assign wr_clr = wr_in && (addr_in == sca_pkg::OFS_CLR_CMD) && units_idle;
	assign wr_rd = wr_in && (addr_in == sca_pkg::OFS_RD_CTRL) && units_idle;
	// Writes to flag and result offsets decode to nothing and are dropped
	assign clr_start = wr_clr && wdata_in[sca_pkg::CLR_BUSY_BIT];
	assign rd_start = wr_rd && wdata_in[sca_pkg::RD_BUSY_BIT];
	assign clr_finish = clr_busy && clr_done_in;
	assign rd_finish = rd_busy && cnt_valid_in;

	// ==========================================================
	// Port clear sequencer
	// Counter logic does the clearing, this side only hands over the job
	always_comb begin
		clr_state_nxt = clr_state_r;
		unique case (clr_state_r)
			sca_pkg::CLR_IDLE: begin
				if (clr_start) begin
					clr_state_nxt = sca_pkg::CLR_RUN;
				end
			end
			sca_pkg::CLR_RUN: begin
				if (clr_done_in) begin
					clr_state_nxt = sca_pkg::CLR_IDLE;
				end
			end
			default: begin
				clr_state_nxt = sca_pkg::CLR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			clr_state_r <= sca_pkg::CLR_IDLE;
		end else if (ce_in) begin
			clr_state_r <= clr_state_nxt;
		end
	end

	// Selection is kept after completion so software can read it back
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			clr_sel_r <= sca_pkg::CLR_SEL_RST;
		end else if (ce_in && wr_clr) begin
			clr_sel_r <= wdata_in[sca_pkg::CLR_SEL_LSB +: sca_pkg::PORTS];
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			clr_req_out <= 1'b0;
		end else if (ce_in) begin
			if (clr_start) begin
				clr_req_out <= 1'b1;
			end else if (clr_finish) begin
				clr_req_out <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			clr_sel_out <= sca_pkg::CLR_SEL_RST;
		end else if (ce_in && clr_start) begin
			clr_sel_out <= wdata_in[sca_pkg::CLR_SEL_LSB +: sca_pkg::PORTS];
		end
	end

	// ==========================================================
	// Indirect counter read
	always_comb begin
		rd_state_nxt = rd_state_r;
		unique case (rd_state_r)
			sca_pkg::RD_IDLE: begin
				if (rd_start) begin
					rd_state_nxt = sca_pkg::RD_FETCH;
				end
			end
			sca_pkg::RD_FETCH: begin
				if (cnt_valid_in) begin
					rd_state_nxt = sca_pkg::RD_IDLE;
				end
			end
			default: begin
				rd_state_nxt = sca_pkg::RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_state_r <= sca_pkg::RD_IDLE;
		end else if (ce_in) begin
			rd_state_r <= rd_state_nxt;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_idx_r <= sca_pkg::RD_IDX_RST;
		end else if (ce_in && wr_rd) begin
			rd_idx_r <= wdata_in[sca_pkg::RD_IDX_LSB +: sca_pkg::IDX_W];
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_req_out <= 1'b0;
		end else if (ce_in) begin
			if (rd_start) begin
				cnt_req_out <= 1'b1;
			end else if (rd_finish) begin
				cnt_req_out <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_index_out <= sca_pkg::RD_IDX_RST;
		end else if (ce_in && rd_start) begin
			cnt_index_out <= wdata_in[sca_pkg::RD_IDX_LSB +: sca_pkg::IDX_W];
		end
	end

	// Result and busy drop update on the same edge, so a poll never sees stale data
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			result_r <= sca_pkg::RESULT_RST;
		end else if (ce_in && rd_finish) begin
			result_r <= cnt_value_in;
		end
	end

	// ==========================================================
	// Register views
	// Spare bits above each field read as zero
	assign tx_view = sca_pkg::DATA_W'(tx_if.flags);
	assign err_view = sca_pkg::DATA_W'(err_if.flags);
	assign col_view = sca_pkg::DATA_W'(col_if.flags);

	always_comb begin
		clr_cmd_view = sca_pkg::RDATA_RST;
		clr_cmd_view[sca_pkg::CLR_SEL_LSB +: sca_pkg::PORTS] = clr_sel_r;
		clr_cmd_view[sca_pkg::CLR_BUSY_BIT] = clr_busy;
	end

	always_comb begin
		rd_ctrl_view = sca_pkg::RDATA_RST;
		rd_ctrl_view[sca_pkg::RD_IDX_LSB +: sca_pkg::IDX_W] = rd_idx_r;
		rd_ctrl_view[sca_pkg::RD_BUSY_BIT] = rd_busy;
	end

	// ==========================================================
	// Read data
	// Data only stand in the cycle after the strobe, zero otherwise
	always_comb begin
		rdata_nxt = sca_pkg::RDATA_RST;
		if (rd_in) begin
			unique case (addr_in)
				sca_pkg::OFS_TX_LEN_OVF: begin
					rdata_nxt = tx_view;
				end
				sca_pkg::OFS_ERR_OVF: begin
					rdata_nxt = err_view;
				end
				sca_pkg::OFS_COL_OVF: begin
					rdata_nxt = col_view;
				end
				sca_pkg::OFS_CLR_CMD: begin
					rdata_nxt = clr_cmd_view;
				end
				sca_pkg::OFS_RD_CTRL: begin
					rdata_nxt = rd_ctrl_view;
				end
				sca_pkg::OFS_RD_RESULT: begin
					rdata_nxt = result_r;
				end
				default: begin
					rdata_nxt = sca_pkg::RDATA_RST;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_r <= sca_pkg::RDATA_RST;
		end else if (ce_in) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_out = rdata_r;
endmodule

// ### logic/sca_sticky.sv
`timescale 1ns/1ns
module sca_sticky #(
	parameter int unsigned WIDTH = 26
) (
	input wire logic clock_in, // Core clock
	input wire logic arst_n_in, // Async reset, active low
	sca_flag_if.owner fl // Set, read-clear and flag vector
);
	logic [WIDTH-1:0] flags_r;
	logic [WIDTH-1:0] flags_nxt;

	// ==========================================================
	// Clear on read, set wins over the clear
	always_comb begin
		flags_nxt = flags_r;
		if (fl.rd_clr) begin
			flags_nxt = '0;
		end
		flags_nxt = flags_nxt | fl.set;
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flags_r <= WIDTH'(sca_pkg::FLAGS_RST);
		end else if (fl.ce) begin
			flags_r <= flags_nxt;
		end
	end

	assign fl.flags = flags_r;
endmodule

// ### tb/sca_stat_access_bench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
// ==========
// Bench
module sca_stat_access_bench;
	logic clock_in = 1'b0;
	logic arst_n_in, ce_in, wr_in, rd_in, clr_done_in, cnt_valid_in, clr_req_out, cnt_req_out;
	logic [7:0] addr_in, cnt_index_out, ix;
	logic [31:0] wdata_in, rdata_out, cnt_value_in, rv, v;
	logic [25:0] tx_len_ovf_in, err_ovf_in, col_ovf_in, clr_sel_out, s;
	integer seed = 32'hCB934F33;
	int err_total = 0;
	int checked = 0;
	int cycles = 0;

	always #20 clock_in = ~clock_in;

	sca_stat_access DUT (.clock_in, .arst_n_in, .ce_in, .addr_in, .wdata_in, .wr_in,
		.rd_in, .rdata_out, .tx_len_ovf_in, .err_ovf_in, .col_ovf_in, .clr_req_out,
		.clr_sel_out, .clr_done_in, .cnt_req_out, .cnt_index_out, .cnt_value_in,
		.cnt_valid_in);

	// ==========
	// Bus and event tasks
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 rv = rdata_out;
	endtask
	task pulse(input int k, input logic [25:0] p);
		@(posedge clock_in);
		case (k)
			0: tx_len_ovf_in <= p;
			1: err_ovf_in <= p;
			default: col_ovf_in <= p;
		endcase
		@(posedge clock_in);
		{tx_len_ovf_in, err_ovf_in, col_ovf_in} <= '0;
	endtask
	task results;
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Control word: field from bit 0 up, access bit at pos
	function automatic logic [31:0] ctl_exp(input int pos, input logic busy,
		input logic [25:0] field);
		ctl_exp = 32'(field);
		ctl_exp[pos] = busy;
	endfunction

	// Runaway guard, far above the few hundred cycles needed
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 4000) begin
			err_total++;
			results();
		end
	end

	// ==========
	// Main sequence
	initial begin
		arst_n_in = 1'b0;
		ce_in = 1'b1;
		{wr_in, rd_in, clr_done_in, cnt_valid_in} = '0;
		{tx_len_ovf_in, err_ovf_in, col_ovf_in} = '0;
		addr_in = '0;
		wdata_in = '0;
		cnt_value_in = '0;
		repeat (12) @(posedge clock_in);
		arst_n_in <= 1'b1;
		// Reset values, 0x17 unmapped
		for (int a = 8'h11; a <= 8'h17; a++) begin
			rd(a[7:0]);
			`CHK(rv, 32'h00000000)
		end
		// Sticky flags, end ports first
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < 6; i++) begin
				v = $random(seed);
				s = (i == 0) ? 26'h2000001 : v[25:0];
				pulse(k, s);
				rd(sca_pkg::OFS_TX_LEN_OVF + k[7:0]);
				`CHK(rv, {6'h00, s})
				rd(sca_pkg::OFS_TX_LEN_OVF + k[7:0]);
				`CHK(rv, 32'h00000000)
			end
		end
		// Event in the cycle of a clearing read survives it
		pulse(0, 26'h0000010);
		@(posedge clock_in);
		addr_in <= sca_pkg::OFS_TX_LEN_OVF;
		rd_in <= 1'b1;
		tx_len_ovf_in <= 26'h0000100;
		@(posedge clock_in);
		rd_in <= 1'b0;
		tx_len_ovf_in <= '0;
		#1 `CHK(rdata_out, 32'h00000010)
		rd(sca_pkg::OFS_TX_LEN_OVF);
		`CHK(rv, 32'h00000100)
		// Flag words ignore writes, events while frozen are lost
		wr(sca_pkg::OFS_TX_LEN_OVF, 32'hFFFFFFFF);
		@(posedge clock_in);
		ce_in <= 1'b0;
		pulse(0, 26'h3FFFFFF);
		ce_in <= 1'b1;
		rd(sca_pkg::OFS_TX_LEN_OVF);
		`CHK(rv, 32'h00000000)
		// Clear: store, start, refuse fetch, busy readback
		v = $random(seed);
		s = v[25:0];
		wr(sca_pkg::OFS_CLR_CMD, {6'h00, s});
		rd(sca_pkg::OFS_CLR_CMD);
		`CHK(rv, ctl_exp(sca_pkg::CLR_BUSY_BIT, 1'b0, s))
		`CHK(clr_req_out, 1'b0)
		wr(sca_pkg::OFS_CLR_CMD, {5'h00, 1'b1, ~s});
		`CHK(clr_req_out, 1'b1)
		`CHK(clr_sel_out, ~s)
		wr(sca_pkg::OFS_RD_CTRL, 32'h00000105);
		`CHK(cnt_req_out, 1'b0)
		rd(sca_pkg::OFS_CLR_CMD);
		`CHK(rv, ctl_exp(sca_pkg::CLR_BUSY_BIT, 1'b1, ~s))
		@(posedge clock_in);
		clr_done_in <= 1'b1;
		@(posedge clock_in);
		clr_done_in <= 1'b0;
		#1 `CHK(clr_req_out, 1'b0)
		rd(sca_pkg::OFS_CLR_CMD);
		`CHK(rv, ctl_exp(sca_pkg::CLR_BUSY_BIT, 1'b0, ~s))
		rd(sca_pkg::OFS_RD_CTRL);
		`CHK(rv, 32'h00000000)
		// Index stored without access bit: no fetch, output index untouched
		wr(sca_pkg::OFS_RD_CTRL, 32'h000000A5);
		`CHK(cnt_req_out, 1'b0)
		`CHK(cnt_index_out, 8'h00)
		rd(sca_pkg::OFS_RD_CTRL);
		`CHK(rv, ctl_exp(sca_pkg::RD_BUSY_BIT, 1'b0, 26'h00000A5))
		// Fetch: index corners then random, random answer delay
		for (int i = 0; i < 6; i++) begin
			v = $random(seed);
			ix = (i == 0) ? 8'h01 : (i == 1) ? 8'hFF : v[15:8];
			wr(sca_pkg::OFS_RD_CTRL, {23'h000000, 1'b1, ix});
			`CHK(cnt_req_out, 1'b1)
			`CHK(cnt_index_out, ix)
			wr(sca_pkg::OFS_CLR_CMD, 32'h04000001);
			`CHK(clr_req_out, 1'b0)
			rd(sca_pkg::OFS_RD_CTRL);
			`CHK(rv, ctl_exp(sca_pkg::RD_BUSY_BIT, 1'b1, 26'(ix)))
			repeat (v[17:16]) @(posedge clock_in);
			@(posedge clock_in);
			cnt_value_in <= v;
			cnt_valid_in <= 1'b1;
			@(posedge clock_in);
			cnt_valid_in <= 1'b0;
			// Value line no longer held once valid is gone
			cnt_value_in <= ~v;
			addr_in <= sca_pkg::OFS_RD_RESULT;
			rd_in <= 1'b1;
			@(posedge clock_in);
			rd_in <= 1'b0;
			#1 `CHK(rdata_out, v)
			rd(sca_pkg::OFS_RD_CTRL);
			`CHK(rv[8], 1'b0)
		end
		// Reset in mid-run, fetch pending, flags and result loaded
		pulse(2, 26'h3FFFFFF);
		wr(sca_pkg::OFS_RD_CTRL, 32'h0000017F);
		`CHK(cnt_req_out, 1'b1)
		@(posedge clock_in);
		arst_n_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		arst_n_in <= 1'b1;
		#1 `CHK({clr_req_out, cnt_req_out, cnt_index_out, clr_sel_out}, 36'h000000000)
		for (int a = 8'h11; a <= 8'h16; a++) begin
			rd(a[7:0]);
			`CHK(rv, 32'h00000000)
		end
		results();
	end
endmodule

// ### tb/sca_stat_access_properties.sv
`timescale 1ns/1ns
// ==========
// Checker on the top ports
module sca_stat_access_properties (
	input wire logic clock_in, // Clock
	input wire logic arst_n_in, // Reset
	input wire logic ce_in, // Enable
	input wire logic [7:0] addr_in, // Address
	input wire logic [31:0] wdata_in, // Write data
	input wire logic wr_in, // Write
	input wire logic rd_in, // Read
	input wire logic [31:0] rdata_out, // Read data
	input wire logic clr_req_out, // Clear busy
	input wire logic [25:0] clr_sel_out, // Clear ports
	input wire logic clr_done_in, // Clear done
	input wire logic cnt_req_out, // Fetch busy
	input wire logic [7:0] cnt_index_out, // Index
	input wire logic [31:0] cnt_value_in, // Value
	input wire logic cnt_valid_in // Valid
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!arst_n_in);
	logic go_w;
	// Starts only from full idle
	assign go_w = ce_in && wr_in && !clr_req_out && !cnt_req_out;
	sequence s_clr_go;
		go_w && addr_in == sca_pkg::OFS_CLR_CMD && wdata_in[26];
	endsequence
	sequence s_fetch_go;
		go_w && addr_in == sca_pkg::OFS_RD_CTRL && wdata_in[8];
	endsequence
	sequence s_fetch_end;
		cnt_req_out && ce_in && cnt_valid_in;
	endsequence
	sequence s_result_rd;
		ce_in && rd_in && addr_in == sca_pkg::OFS_RD_RESULT;
	endsequence
	a_clr_start: assert property (
		s_clr_go |=> clr_req_out && clr_sel_out == $past(wdata_in[25:0]))
		else $error("clear start wrong");
	a_clr_hold: assert property (
		clr_req_out && !(ce_in && clr_done_in) |=> clr_req_out && $stable(clr_sel_out))
		else $error("clear dropped early");
	a_clr_end: assert property (clr_req_out && ce_in && clr_done_in |=> !clr_req_out)
		else $error("clear not ended");
	a_fetch_start: assert property (
		s_fetch_go |=> cnt_req_out && cnt_index_out == $past(wdata_in[7:0]))
		else $error("fetch start wrong");
	a_fetch_hold: assert property (
		cnt_req_out && !(ce_in && cnt_valid_in) |=> cnt_req_out && $stable(cnt_index_out))
		else $error("fetch dropped early");
	a_fetch_end: assert property (s_fetch_end |=> !cnt_req_out)
		else $error("fetch not ended");
	a_one_busy: assert property (!(clr_req_out && cnt_req_out))
		else $error("clear and fetch together");
	a_busy_read: assert property (
		clr_req_out && ce_in && rd_in && addr_in == sca_pkg::OFS_CLR_CMD |=> rdata_out[26])
		else $error("clear busy bit not read");
	a_result_read: assert property (
		s_fetch_end ##1 s_result_rd |=> rdata_out == $past(cnt_value_in, 2))
		else $error("result not loaded");
endmodule
bind sca_stat_access sca_stat_access_properties u_props (.clock_in, .arst_n_in, .ce_in,
	.addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .clr_req_out, .clr_sel_out,
	.clr_done_in, .cnt_req_out, .cnt_index_out, .cnt_value_in, .cnt_valid_in);
